// File: verilog/fets_map.svh
// Constants for the flash erase / identification sequencer host.
// Assumes a 20 MHz core clock; included by fets_pkg and the design modules.
`ifndef FETS_MAP_SVH
`define FETS_MAP_SVH

// ---------------------------------------------------------------
// Command addresses and data
// ---------------------------------------------------------------
`define FETS_ADDR_555        12'h555
`define FETS_ADDR_AAA        12'haaa
`define FETS_DAT_UNLOCK1     8'haa
`define FETS_DAT_UNLOCK2     8'h55
`define FETS_DAT_ERASE_SETUP 8'h80
`define FETS_DAT_CHIP_ERASE  8'h10
`define FETS_DAT_SECT_ERASE  8'h30
`define FETS_DAT_ID_ENTRY    8'h90
`define FETS_DAT_ID_EXIT     8'hf0
`define FETS_TOGGLE_BIT      6

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define FETS_CLK_NS          50
`define FETS_WP_NS           35
`define FETS_GATE_HIGH_NS    50
`define FETS_ACC_NS          70
`define FETS_WP_CYC          ((`FETS_WP_NS + `FETS_CLK_NS - 1) / `FETS_CLK_NS)
`define FETS_GATE_HIGH_CYC   ((`FETS_GATE_HIGH_NS + `FETS_CLK_NS - 1) / `FETS_CLK_NS)
`define FETS_ACC_CYC         ((`FETS_ACC_NS + `FETS_CLK_NS - 1) / `FETS_CLK_NS)

`endif

// File: verilog/fets_pkg.sv
// Types for the flash erase / identification sequencer host.
// Assumes fets_map.svh is on the include path.
`default_nettype none
`include "fets_map.svh"
package fets_pkg;
   typedef enum logic [2:0] {
      FETS_OP_NONE     = 3'b000,
      FETS_OP_CHIP_ER  = 3'b001,
      FETS_OP_SECT_ER  = 3'b010,
      FETS_OP_ID_ENTRY = 3'b011,
      FETS_OP_ID_READ  = 3'b100,
      FETS_OP_ID_EXIT  = 3'b101,
      FETS_OP_READ     = 3'b110
   } fets_op_e;
   typedef enum logic [1:0] {
      FETS_CY_IDLE  = 2'b00,
      FETS_CY_WRITE = 2'b01,
      FETS_CY_READ  = 2'b10
   } fets_cyc_e;
endpackage : fets_pkg
`default_nettype wire

// File: verilog/fets_bus_cycle.sv
// One asynchronous flash bus cycle (word write or word read).
// Latches address and data at start; the caller may change them while busy.
`timescale 1ns/10ps
`default_nettype none
`include "fets_map.svh"
module fets_bus_cycle
   import fets_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        start_i,
   input  wire logic        write_i,
   input  wire logic [20:0] addr_i,
   input  wire logic [15:0] wdata_i,
   output logic             done_o,
   output logic [15:0]      rdata_o,
   output logic             ce_b_o,
   output logic             oe_b_o,
   output logic             we_b_o,
   output logic [20:0]      addr_o,
   output logic [15:0]      dq_o,
   output logic             dq_oe_o,
   input  wire logic [15:0] dq_i
);
   // ---------------------------------------------------------------
   // Cycle sequencer
   // ---------------------------------------------------------------
   fets_cyc_e   st_r, st_nxt;
   logic [1:0]  cnt_r, cnt_nxt;
   logic [15:0] rd_r, rd_nxt;
   logic        dn_r, dn_nxt;
   logic [20:0] a_r, a_nxt;
   logic [15:0] d_r, d_nxt;

   // Strobe widths: write pulse, then a high phase of the same length
   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = cnt_r;
      rd_nxt  = rd_r;
      dn_nxt  = 1'b0;
      a_nxt   = a_r;
      d_nxt   = d_r;
      case (st_r)
         FETS_CY_IDLE: begin
            if (start_i) begin
               a_nxt   = addr_i;
               d_nxt   = wdata_i;
               cnt_nxt = 2'h0;
               st_nxt  = write_i ? FETS_CY_WRITE : FETS_CY_READ;
            end
         end
         FETS_CY_WRITE: begin
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == 2'(`FETS_WP_CYC)) begin
               dn_nxt = 1'b1;
               st_nxt = FETS_CY_IDLE;
            end
         end
         FETS_CY_READ: begin
            cnt_nxt = cnt_r + 2'h1;
            if (cnt_r == 2'(`FETS_ACC_CYC)) begin
               rd_nxt = dq_i;           // Sampled after access time
               dn_nxt = 1'b1;
               st_nxt = FETS_CY_IDLE;
            end
         end
         default: st_nxt = FETS_CY_IDLE;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r  <= FETS_CY_IDLE;
         cnt_r <= 2'h0;
         rd_r  <= 16'h0000;
         dn_r  <= 1'b0;
         a_r   <= 21'h000000;
         d_r   <= 16'h0000;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         rd_r  <= rd_nxt;
         dn_r  <= dn_nxt;
         a_r   <= a_nxt;
         d_r   <= d_nxt;
      end
   end

   // Pins; the gate stays high for every write phase
   assign ce_b_o  = (st_r == FETS_CY_IDLE);
   assign we_b_o  = !((st_r == FETS_CY_WRITE) && (cnt_r < 2'(`FETS_WP_CYC)));
   assign oe_b_o  = (st_r != FETS_CY_READ);
   assign dq_oe_o = (st_r == FETS_CY_WRITE);
   assign addr_o  = a_r;
   assign dq_o    = d_r;
   assign done_o  = dn_r;
   assign rdata_o = rd_r;
endmodule : fets_bus_cycle
`default_nettype wire

// File: verilog/fets_host.sv
// Host sequencer driving a parallel NOR flash: erase, toggle polling, ID.
// Assumes a single flash on the pins and synchronous pin inputs.
// Function
// - Chip erase final write goes to address 555.
// - Final erase byte 10 selects chip erase, 30 sector erase.
// - Sector erase final write address lies inside the target sector.
// - Output gate held high while write strobe and select are low.
// - Each high pulse of the polled strobe lasts at least 50 ns.
// - Status on bit 6; completion judged only by change between reads.
// - Every status read uses the same address.
// - ID entry is AA to 555, 55 to AAA, 90 to 555.
`timescale 1ns/10ps
`default_nettype none
`include "fets_map.svh"
module fets_host
   import fets_pkg::*;
(
   input  wire logic        core_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        req_i,
   input  wire logic [2:0]  op_i,
   input  wire logic [20:0] addr_i,
   output logic             busy_o,
   output logic             done_o,
   output logic [15:0]      rdata_o,
   output logic             id_mode_o,
   output logic             ce_b_o,
   output logic             oe_b_o,
   output logic             we_b_o,
   output logic [20:0]      flash_addr_o,
   output logic [15:0]      dq_o,
   output logic             dq_oe_o,
   input  wire logic [15:0] dq_i
);
   // ---------------------------------------------------------------
   // Sequencer state
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      FETS_S_IDLE = 2'b00,
      FETS_S_CMD  = 2'b01,
      FETS_S_POLL = 2'b10,
      FETS_S_DONE = 2'b11
   } fets_seq_e;

   fets_seq_e   st_r, st_nxt;
   fets_op_e    op_r, op_nxt;
   logic [2:0]  step_r, step_nxt;
   logic [20:0] tgt_r, tgt_nxt;
   logic        issued_r, issued_nxt;
   logic        have_prev_r, have_prev_nxt;
   logic        prev_t_r, prev_t_nxt;
   logic [15:0] res_r, res_nxt;
   logic        idm_r, idm_nxt;
   logic        dn_r, dn_nxt;

   logic        cy_start;
   logic        cy_write;
   logic [20:0] cy_addr;
   logic [15:0] cy_wdata;
   logic        cy_done;
   logic [15:0] cy_rdata;
   logic [2:0]  nsteps;
   logic [11:0] cmd_a;
   logic [7:0]  cmd_d;

   // ---------------------------------------------------------------
   // Command table per step
   // ---------------------------------------------------------------
   // Upper address and data bits are don't-care to the flash; drive zeros
   always_comb begin
      cmd_a  = `FETS_ADDR_555;
      cmd_d  = `FETS_DAT_UNLOCK1;
      nsteps = 3'h3;
      case (op_r)
         FETS_OP_CHIP_ER, FETS_OP_SECT_ER: begin
            nsteps = 3'h6;
            case (step_r)
               3'h1: begin cmd_a = `FETS_ADDR_AAA; cmd_d = `FETS_DAT_UNLOCK2; end
               3'h2: cmd_d = `FETS_DAT_ERASE_SETUP;
               3'h4: begin cmd_a = `FETS_ADDR_AAA; cmd_d = `FETS_DAT_UNLOCK2; end
               3'h5: cmd_d = (op_r == FETS_OP_CHIP_ER) ? `FETS_DAT_CHIP_ERASE
                                                       : `FETS_DAT_SECT_ERASE;
               default: cmd_d = `FETS_DAT_UNLOCK1;
            endcase
         end
         FETS_OP_ID_ENTRY, FETS_OP_ID_EXIT: begin
            case (step_r)
               3'h1: begin cmd_a = `FETS_ADDR_AAA; cmd_d = `FETS_DAT_UNLOCK2; end
               3'h2: cmd_d = (op_r == FETS_OP_ID_ENTRY) ? `FETS_DAT_ID_ENTRY
                                                        : `FETS_DAT_ID_EXIT;
               default: cmd_d = `FETS_DAT_UNLOCK1;
            endcase
         end
         default: nsteps = 3'h1;
      endcase
   end

   // Bus cycle request: command write, ID/normal read, or status read
   always_comb begin
      cy_start = 1'b0;
      cy_write = 1'b0;
      cy_addr  = {9'h000, cmd_a};
      cy_wdata = {8'h00, cmd_d};
      if (st_r == FETS_S_CMD && !issued_r) begin
         cy_start = 1'b1;
         // Anything but a command op is one read, so a stray code never writes
         if (!(op_r inside {FETS_OP_CHIP_ER, FETS_OP_SECT_ER, FETS_OP_ID_ENTRY, FETS_OP_ID_EXIT})) begin
            cy_addr = (op_r == FETS_OP_ID_READ) ? {20'h00000, tgt_r[0]} : tgt_r;
         end else begin
            cy_write = 1'b1;
            if (op_r == FETS_OP_SECT_ER && step_r == 3'h5) begin
               cy_addr = tgt_r;
            end else if (op_r == FETS_OP_CHIP_ER && step_r == 3'h5) begin
               cy_addr = {9'h000, `FETS_ADDR_555};
            end
         end
      end else if (st_r == FETS_S_POLL && !issued_r) begin
         cy_start = 1'b1;
         cy_addr  = tgt_r;
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   // No internal erase timer: completion comes from the flash itself,
   // so erase lengths of seconds cost no counter here
   always_comb begin
      st_nxt        = st_r;
      op_nxt        = op_r;
      step_nxt      = step_r;
      tgt_nxt       = tgt_r;
      issued_nxt    = issued_r;
      have_prev_nxt = have_prev_r;
      prev_t_nxt    = prev_t_r;
      res_nxt       = res_r;
      idm_nxt       = idm_r;
      dn_nxt        = 1'b0;
      if (cy_start) begin
         issued_nxt = 1'b1;
      end
      case (st_r)
         FETS_S_IDLE: begin
            if (req_i) begin
               op_nxt      = fets_op_e'(op_i);
               tgt_nxt     = addr_i;
               step_nxt    = 3'h0;
               issued_nxt  = 1'b0;
               have_prev_nxt = 1'b0;
               st_nxt      = FETS_S_CMD;
            end
         end
         FETS_S_CMD: begin
            if (cy_done) begin
               issued_nxt = 1'b0;
               step_nxt   = step_r + 3'h1;
               if (step_r + 3'h1 >= nsteps) begin
                  res_nxt = cy_rdata;
                  if (op_r == FETS_OP_CHIP_ER || op_r == FETS_OP_SECT_ER) begin
                     st_nxt = FETS_S_POLL;
                  end else begin
                     if (op_r == FETS_OP_ID_ENTRY) idm_nxt = 1'b1;
                     if (op_r == FETS_OP_ID_EXIT) idm_nxt = 1'b0;
                     st_nxt = FETS_S_DONE;
                  end
               end
            end
         end
         FETS_S_POLL: begin
            // Gate returns high between reads for two cycles, covering 50 ns
            if (cy_done) begin
               issued_nxt    = 1'b0;
               have_prev_nxt = 1'b1;
               prev_t_nxt    = cy_rdata[`FETS_TOGGLE_BIT];
               res_nxt       = cy_rdata;
               // Level itself means nothing; only a change between reads
               if (have_prev_r && (cy_rdata[`FETS_TOGGLE_BIT] == prev_t_r)) begin
                  st_nxt = FETS_S_DONE;
               end
            end
         end
         FETS_S_DONE: begin
            dn_nxt = 1'b1;
            st_nxt = FETS_S_IDLE;
         end
         default: st_nxt = FETS_S_IDLE;
      endcase
   end

   // Reset stands for power-up, where the flash leaves ID mode too
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_r        <= FETS_S_IDLE;
         op_r        <= FETS_OP_NONE;
         step_r      <= 3'h0;
         tgt_r       <= 21'h000000;
         issued_r    <= 1'b0;
         have_prev_r <= 1'b0;
         prev_t_r    <= 1'b0;
         res_r       <= 16'h0000;
         idm_r       <= 1'b0;
         dn_r        <= 1'b0;
      end else begin
         st_r        <= st_nxt;
         op_r        <= op_nxt;
         step_r      <= step_nxt;
         tgt_r       <= tgt_nxt;
         issued_r    <= issued_nxt;
         have_prev_r <= have_prev_nxt;
         prev_t_r    <= prev_t_nxt;
         res_r       <= res_nxt;
         idm_r       <= idm_nxt;
         dn_r        <= dn_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Pin driver
   // ---------------------------------------------------------------
   fets_bus_cycle u_cyc (
      .core_clk_i (core_clk_i),
      .rst_b_i    (rst_b_i),
      .start_i    (cy_start),
      .write_i    (cy_write),
      .addr_i     (cy_addr),
      .wdata_i    (cy_wdata),
      .done_o     (cy_done),
      .rdata_o    (cy_rdata),
      .ce_b_o     (ce_b_o),
      .oe_b_o     (oe_b_o),
      .we_b_o     (we_b_o),
      .addr_o     (flash_addr_o),
      .dq_o       (dq_o),
      .dq_oe_o    (dq_oe_o),
      .dq_i       (dq_i)
   );

   assign busy_o    = (st_r != FETS_S_IDLE);
   assign done_o    = dn_r;
   assign rdata_o   = res_r;
   assign id_mode_o = idm_r;
endmodule : fets_host
`default_nettype wire

// File: tb/fets_host_chk.sv
// Pin and handshake checker for the flash host sequencer.
// Assumes it is bound to fets_host and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fets_host_chk (
   input wire logic        core_clk_i,
   input wire logic        rst_b_i,
   input wire logic        req_i,
   input wire logic        busy_o,
   input wire logic        done_o,
   input wire logic        id_mode_o,
   input wire logic        ce_b_o,
   input wire logic        oe_b_o,
   input wire logic        we_b_o,
   input wire logic [15:0] dq_o,
   input wire logic        dq_oe_o
);
   // ---------------------------------------------
   // Strobe and handshake properties
   // ---------------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   // Gate shut whenever a write strobe is active
   AST_GATE_HI: assert property (!we_b_o && !ce_b_o |-> oe_b_o)
      else $error("gate open during write");
   // Host lets go of the data lines while reading
   AST_RD_FREE: assert property (!oe_b_o |-> !dq_oe_o)
      else $error("host drives data during read");
   AST_WR_DRV: assert property (!we_b_o |-> dq_oe_o && !ce_b_o)
      else $error("write without select or data");
   // Upper byte of every command word is zero
   AST_HI_BYTE: assert property (!we_b_o |-> dq_o[15:8] == 8'h00)
      else $error("upper command byte not zero");
   AST_SEL_READ: assert property ($fell(oe_b_o) |-> !ce_b_o && we_b_o)
      else $error("gate opened without select");
   AST_DONE_ONE: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   AST_DONE_IDLE: assert property (done_o |=> !busy_o)
      else $error("busy after done");
   AST_TAKE: assert property (req_i && !busy_o |=> busy_o)
      else $error("request not taken");
   AST_ID_RST: assert property ($rose(rst_b_i) |-> !id_mode_o)
      else $error("id mode after reset");
   // Main scenarios
   COV_ID: cover property (done_o && id_mode_o);
   COV_EXIT: cover property ($fell(id_mode_o));
   COV_REFUSE: cover property (req_i && busy_o);
endmodule : fets_host_chk
bind fets_host fets_host_chk i_fets_host_chk (.core_clk_i, .rst_b_i, .req_i, .busy_o,
   .done_o, .id_mode_o, .ce_b_o, .oe_b_o, .we_b_o, .dq_o, .dq_oe_o);
`default_nettype wire

// File: tb/fets_flash_mdl.sv
// Behavioural NOR flash: command decode, toggle status and ID mode.
// Assumes clean host strobes; erase time is counted in status reads.
`timescale 1ns/10ps
`default_nettype none
module fets_flash_mdl #(
   parameter logic [15:0] MFR_CODE = 16'h00a5, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h0c3e, // Arbitrary value
   parameter int          RD_4K    = 3,
   parameter int          RD_32K   = 6,
   parameter int          RD_CHIP  = 12
) (
   input  wire logic        pwr_i,
   input  wire logic        ce_b_i,
   input  wire logic        oe_b_i,
   input  wire logic        we_b_i,
   input  wire logic [20:0] addr_i,
   input  wire logic [15:0] dq_i,
   output logic [15:0]      dq_o,
   output logic             id_o,
   output logic             busy_o,
   output logic [7:0]       cmd_o,
   output logic [6:0]       sect_o,
   output int               rd_cnt_o,
   output int               err_o
);
   // ---------------------------------------------
   // Command, read and power behaviour
   // ---------------------------------------------
   logic [119:0] hist;
   logic [20:0]  paddr;
   logic         rd_on;
   logic         tgl;
   int           rem;
   realtime      t_rise;
   initial begin
      {hist, paddr, rd_on, tgl, id_o, busy_o, cmd_o, sect_o, dq_o} = '0;
      {rem, rd_cnt_o, err_o} = '0;
      t_rise = 0.0;
   end
   // Decode on the closing write strobe; only low byte and low address count
   always @(posedge we_b_i) if (!ce_b_i) begin
      hist = {hist[99:0], addr_i[11:0], dq_i[7:0]};
      if (hist[59:0] == 60'h555aaaaa5555590) id_o = 1'b1;
      if (hist[7:0] == 8'hf0) id_o = 1'b0;
      if (hist[119:20] == 100'h555aaaaa5555580555aaaaa55 &&
          (hist[19:0] == 20'h55510 || hist[7:0] == 8'h30)) begin
         cmd_o = hist[7:0];
         sect_o = (addr_i < 21'h1f8000) ? {1'b0, addr_i[20:15]} : 7'd63 + {4'h0, addr_i[14:12]};
         if (cmd_o == 8'h10) sect_o = 7'h7f;
         rem = (cmd_o == 8'h10) ? RD_CHIP : (addr_i >= 21'h1f8000) ? RD_4K : RD_32K;
         busy_o = 1'b1;
         rd_cnt_o = 0;
      end
   end
   // Each select-and-gate read gives status or data; late settle of pins
   always @(negedge oe_b_i or negedge ce_b_i) begin
      #1;
      if (!oe_b_i && !ce_b_i && we_b_i && !rd_on) begin
         rd_on = 1'b1;
         if (busy_o) begin
            if (rd_cnt_o == 0) paddr = addr_i;
            if (addr_i != paddr || $realtime - t_rise < 51.0) err_o++;
            tgl = ~tgl;
            dq_o = {9'h000, tgl, 6'h00};
            rem--;
            busy_o = (rem > 0);
         end else if (id_o && addr_i[20:1] == 20'h00000) dq_o = addr_i[0] ? DEV_CODE : MFR_CODE;
         else dq_o = addr_i[15:0] ^ 16'h3c3c;
         rd_cnt_o++;
      end
   end
   // Released lines show the inverse of the last word, never a stale copy
   always @(posedge oe_b_i or posedge ce_b_i) if (rd_on) begin
      rd_on = 1'b0;
      t_rise = $realtime;
      dq_o = ~dq_o;
   end
   // Power loss drops ID mode and any operation
   always @(negedge pwr_i) begin
      id_o = 1'b0;
      busy_o = 1'b0;
   end
endmodule : fets_flash_mdl
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench: host sequencer against the behavioural flash.
// Assumes fets_pkg, fets_host, its checker and the flash model compiled.
`timescale 1ns/10ps
`default_nettype none
module tb
   import fets_pkg::*;
;
   // ---------------------------------------------
   // Bench, stimulus and checks
   // ---------------------------------------------
   localparam logic [15:0] MFR = 16'h00a5; // Arbitrary value
   localparam logic [15:0] DEV = 16'h0c3e; // Arbitrary value
   localparam int RD_4K = 3, RD_32K = 6, RD_CHIP = 12;
   logic        core_clk = 1'b0;
   logic        rst_b    = 1'b0;
   logic        req      = 1'b0;
   logic [2:0]  op       = 3'h0;
   logic [20:0] addr     = 21'h000000;
   logic        pwr      = 1'b1;
   logic        busy, done, id_mode, ce_b, oe_b, we_b, h_dq_oe, m_id, m_busy;
   logic [15:0] rdata, h_dq, m_dq;
   logic [20:0] f_addr;
   logic [7:0]  m_cmd;
   logic [6:0]  m_sect;
   logic [31:0] seed = 32'he64c7a78;
   int          m_rd, m_err;
   int          fails = 0, num_checks = 0, cyc = 0;
   wire  logic [15:0] bus = h_dq_oe ? h_dq : m_dq;
   always #25 core_clk = ~core_clk;
   fets_host i_fets_host (.core_clk_i(core_clk), .rst_b_i(rst_b), .req_i(req), .op_i(op),
      .addr_i(addr), .busy_o(busy), .done_o(done), .rdata_o(rdata), .id_mode_o(id_mode),
      .ce_b_o(ce_b), .oe_b_o(oe_b), .we_b_o(we_b), .flash_addr_o(f_addr), .dq_o(h_dq),
      .dq_oe_o(h_dq_oe), .dq_i(bus));
   fets_flash_mdl #(.MFR_CODE(MFR), .DEV_CODE(DEV), .RD_4K(RD_4K), .RD_32K(RD_32K),
      .RD_CHIP(RD_CHIP)) i_fets_flash_mdl (.pwr_i(pwr), .ce_b_i(ce_b), .oe_b_i(oe_b),
      .we_b_i(we_b), .addr_i(f_addr), .dq_i(bus), .dq_o(m_dq), .id_o(m_id),
      .busy_o(m_busy), .cmd_o(m_cmd), .sect_o(m_sect), .rd_cnt_o(m_rd), .err_o(m_err));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // Sector number from the boundary layout, worked out by division
   function automatic logic [6:0] exp_sect(input logic [20:0] a);
      if (a >= 21'h1f8000) return 7'(63 + (a - 21'h1f8000) / 4096);
      return 7'(a / 32768);
   endfunction : exp_sect
   task automatic chk(input logic [20:0] got, input logic [20:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   // One request; poke sends a refused ID request while busy
   task automatic run(input fets_op_e o, input logic [20:0] a, input bit poke);
      int n;
      n = 0;
      while (busy !== 1'b0) @(negedge core_clk);
      @(posedge core_clk);
      req <= 1'b1;
      op <= o;
      addr <= a;
      @(posedge core_clk);
      req <= 1'b0;
      if (poke) begin
         repeat (3) @(posedge core_clk);
         req <= 1'b1;
         op <= FETS_OP_ID_ENTRY;
         @(posedge core_clk);
         req <= 1'b0;
      end
      while (done !== 1'b1 && n < 3000) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 3000) begin
         fails++;
         finish_test();
      end
   endtask : run
   // Cycle ceiling well above the whole sequence
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         finish_test();
      end
   end
   initial begin
      logic [20:0] a;
      logic [20:0] tbl [4];
      tbl = '{21'h000000, 21'h1f7fff, 21'h1f8000, 21'h1fffff};
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      @(negedge core_clk);
      chk({rdata, id_mode}, 17'h00000);
      // ID entry, both codes, then random ID reads
      run(FETS_OP_ID_ENTRY, 21'h000000, 1'b0);
      chk({id_mode, m_id}, 2'b11);
      for (int i = 0; i < 6; i++) begin
         a = (i < 2) ? 21'(i) : 21'(xs());
         run(FETS_OP_ID_READ, a, 1'b0);
         chk(rdata, a[0] ? DEV : MFR);
      end
      run(FETS_OP_ID_EXIT, 21'h000000, 1'b0);
      chk({id_mode, m_id}, 2'b00);
      for (int i = 0; i < 5; i++) begin
         a = 21'(xs());
         run((i == 0) ? FETS_OP_NONE : FETS_OP_READ, a, 1'b0);
         chk(rdata, a[15:0] ^ 16'h3c3c);
      end
      // Power loss with a mid-run reset while in ID mode; address 0 tells ID from array
      run(FETS_OP_ID_ENTRY, 21'h000000, 1'b0);
      @(posedge core_clk);
      rst_b <= 1'b0;
      pwr   <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      pwr   <= 1'b1;
      @(negedge core_clk);
      chk({rdata, id_mode, m_id}, 18'h00000);
      run(FETS_OP_READ, 21'h000000, 1'b0);
      chk(rdata, 16'h3c3c);
      run(FETS_OP_ID_EXIT, 21'h000000, 1'b0);
      // Sector erases at layout boundaries and random, with refused requests
      for (int i = 0; i < 7; i++) begin
         a = (i < 4) ? tbl[i] : 21'(xs());
         run(FETS_OP_SECT_ER, a, 1'b1);
         chk({m_cmd, m_sect}, {8'h30, exp_sect(a)});
         chk({m_busy, m_id}, 2'b00);
         chk(m_rd > ((a >= 21'h1f8000) ? RD_4K : RD_32K), 1'b1);
      end
      run(FETS_OP_CHIP_ER, 21'(xs()), 1'b1);
      chk({m_cmd, m_sect}, {8'h10, 7'h7f});
      chk({m_busy, m_rd > RD_CHIP}, 2'b01);
      chk(m_err == 0, 1'b1);
      finish_test();
   end
endmodule : tb
`default_nettype wire
